// ### hdl/wdt_pkg.sv
// Constants, types and register map of the watchdog interval timer
package wdt_pkg;
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_COUNT  = 12'h004;
	localparam logic [11:0] ADDR_RSTCTL = 12'h008;
	localparam logic [11:0] ADDR_PWR    = 12'h00C;
	localparam logic [7:0]  KEY_COUNT   = 8'h5A;
	localparam logic [7:0]  KEY_CTRL    = 8'hA5;
	localparam logic [7:0]  COUNT_ZERO  = 8'h00;
	localparam logic [7:0]  COUNT_MAX   = 8'hFF;
	localparam int          BIT_FLAG    = 7;
	localparam int          BIT_MODE    = 6;
	localparam int          BIT_RUN     = 5;
	localparam int          BIT_CRE     = 6;
	localparam logic [1:0]  CTRL_RSVD   = 2'b11;
	localparam logic [4:0]  RST_RSVD    = 5'b1_1111;
	localparam int          CLK_MHZ     = 100;
	localparam int          OVF_OUT_CYC = 128;
	localparam int          CHIP_RST_CYC = 512;
	localparam int          DIV_W       = 13;

	typedef struct packed {
		logic       flag;
		logic       mode;
		logic       run;
		logic [2:0] clk_sel;
	} ctrl_t;

	typedef enum logic [1:0] {PWR_RUN, PWR_STANDBY, PWR_WAKE} pwr_state_t;
endpackage : wdt_pkg

// ### hdl/pulse_stretch.sv
// Fixed-length pulse generator used for overflow output and chip reset
`timescale 1ns/10ps
module pulse_stretch #(
	parameter int LEN = 128
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic start,
	output logic      active
);
	localparam int W = $clog2(LEN + 1);
	logic [W-1:0] remaining;

	if (LEN < 1) begin : g_len_check
		$error("pulse_stretch: LEN must be at least 1");
	end

	// Output from a flop so the pin cannot glitch while the count ripples
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remaining <= '0;
			active    <= 1'b0;
		end else if (start) begin
			remaining <= W'(LEN - 1);
			active    <= 1'b1;
		end else if (remaining != '0) begin
			remaining <= remaining - W'(1);
		end else begin
			active <= 1'b0;
		end
	end
endmodule : pulse_stretch

// ### hdl/watchdog_unit.sv
// Watchdog / interval timer with APB register access and standby wake
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module watchdog_unit
	import wdt_pkg::*;
#(
	parameter int OVF_LEN = OVF_OUT_CYC,
	parameter int RST_LEN = CHIP_RST_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        nmi_req,
	output logic             overflow_out_n,
	output logic             chip_reset,
	output logic             interval_irq,
	output logic             standby,
	output logic             standby_refused,
	output logic             hold_por_regs
);
	// Pulse lengths must fit the 16-bit length checkers below
	if (OVF_LEN < 1 || RST_LEN < 1 || OVF_LEN >= 2**16 || RST_LEN >= 2**16) begin : g_len_check
		$error("watchdog_unit: pulse lengths must lie in 1 to 65535");
	end

	// Register state
	ctrl_t      timer_ctrl_status;
	logic       watchdog_overflow_flag;
	logic       chip_reset_enable;
	logic [7:0] tick_counter;
	logic [DIV_W-1:0] prescale;
	pwr_state_t pwr_state;
	logic       nmi_meta;
	logic       nmi_sync;
	logic       prescale_q;

	// Bus decode
	wire        wr_access  = psel && penable && pwrite;
	wire        rd_setup   = psel && !penable && !pwrite;
	wire [7:0]  key        = pwdata[15:8];
	wire [7:0]  wdata      = pwdata[7:0];
	wire        hit_shared = (paddr == ADDR_CTRL) || (paddr == ADDR_COUNT);
	wire        wr_count   = wr_access && hit_shared && key == KEY_COUNT;
	wire        wr_ctrl    = wr_access && hit_shared && key == KEY_CTRL;
	wire        wr_rst     = wr_access && paddr == ADDR_RSTCTL;
	wire        clr_wflag  = wr_rst && key == KEY_CTRL && wdata == COUNT_ZERO;
	wire        set_cre    = wr_rst && key == KEY_COUNT;
	wire        wr_pwr     = wr_access && paddr == ADDR_PWR && wdata[0];
	wire        mapped     = hit_shared || paddr == ADDR_RSTCTL || paddr == ADDR_PWR;

	// Clock select: selected prescaler bit, tick on its rising edge
	logic       sel_bit;
	always_comb begin
		case (timer_ctrl_status.clk_sel)
			3'd0:    sel_bit = prescale[0];
			3'd1:    sel_bit = prescale[5];
			3'd2:    sel_bit = prescale[6];
			3'd3:    sel_bit = prescale[7];
			3'd4:    sel_bit = prescale[8];
			3'd5:    sel_bit = prescale[9];
			3'd6:    sel_bit = prescale[11];
			default: sel_bit = prescale[12];
		endcase
	end

	wire counting = timer_ctrl_status.run || pwr_state == PWR_WAKE;
	wire tick     = counting && sel_bit && !prescale_q;
	wire overflow = tick && tick_counter == COUNT_MAX && !wr_count;
	wire ovf_wd   = overflow && timer_ctrl_status.mode && pwr_state == PWR_RUN;
	wire ovf_it   = overflow && !timer_ctrl_status.mode && pwr_state == PWR_RUN;
	wire wd_rst   = ovf_wd && chip_reset_enable;
	// A watchdog-mode overflow clears counter and control either way: the chip reset would
	// do so too, and a running count must not retrigger the reset pulse
	wire soft_clr = ovf_wd;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale   <= '0;
			prescale_q <= 1'b0;
		end else begin
			prescale   <= counting ? prescale + DIV_W'(1) : '0;
			prescale_q <= counting ? sel_bit : 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_meta <= 1'b0;
			nmi_sync <= 1'b0;
		end else begin
			nmi_meta <= nmi_req;
			nmi_sync <= nmi_meta;
		end
	end

	// Counter: write has priority over a coincident tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_counter <= COUNT_ZERO;
		end else if (wr_count) begin
			tick_counter <= wdata;
		end else if (soft_clr || !counting) begin
			tick_counter <= COUNT_ZERO;
		end else if (tick) begin
			tick_counter <= tick_counter + 8'h01;
		end
	end

	// Control/status; interval flag set beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_ctrl_status <= '0;
		end else if (soft_clr) begin
			timer_ctrl_status <= '0;
		end else begin
			if (wr_ctrl) begin
				timer_ctrl_status.mode    <= wdata[BIT_MODE];
				timer_ctrl_status.run     <= wdata[BIT_RUN];
				timer_ctrl_status.clk_sel <= wdata[2:0];
			end
			if (ovf_it) begin
				timer_ctrl_status.flag <= 1'b1;
			end else if (wr_ctrl && !wdata[BIT_FLAG]) begin
				timer_ctrl_status.flag <= 1'b0;
			end
		end
	end

	// Reset control; the internal reset never clears these, only presetn does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_overflow_flag <= 1'b0;
			chip_reset_enable      <= 1'b0;
		end else begin
			if (ovf_wd) begin
				watchdog_overflow_flag <= 1'b1;
			end else if (clr_wflag) begin
				watchdog_overflow_flag <= 1'b0;
			end
			if (set_cre) begin
				chip_reset_enable <= wdata[BIT_CRE];
			end
		end
	end

	// Standby sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_state       <= PWR_RUN;
			standby_refused <= 1'b0;
		end else begin
			standby_refused <= wr_pwr && timer_ctrl_status.run;
			case (pwr_state)
				PWR_RUN: begin
					if (wr_pwr && !timer_ctrl_status.run) pwr_state <= PWR_STANDBY;
				end
				PWR_STANDBY: begin
					if (nmi_sync) pwr_state <= PWR_WAKE;
				end
				PWR_WAKE: begin
					if (tick && tick_counter == COUNT_MAX) pwr_state <= PWR_RUN;
				end
				default: pwr_state <= PWR_RUN;
			endcase
		end
	end

	logic ovf_active;
	logic rst_active;

	pulse_stretch #(.LEN(OVF_LEN)) u_ovf_pulse (
		.pclk   (pclk),
		.presetn(presetn),
		.start  (ovf_wd),
		.active (ovf_active)
	);

	pulse_stretch #(.LEN(RST_LEN)) u_rst_pulse (
		.pclk   (pclk),
		.presetn(presetn),
		.start  (wd_rst),
		.active (rst_active)
	);

	assign overflow_out_n = !ovf_active;
	assign chip_reset     = rst_active;
	// Port and pin function registers stay on presetn only; this tells them so
	assign hold_por_regs  = rst_active;
	assign interval_irq   = timer_ctrl_status.flag && !timer_ctrl_status.mode;
	assign standby        = pwr_state != PWR_RUN;

	// Read data registered in setup so the access phase completes at once
	wire [31:0] rd_ctrl  = {24'h00_0000, timer_ctrl_status.flag, timer_ctrl_status.mode,
		timer_ctrl_status.run, CTRL_RSVD, timer_ctrl_status.clk_sel};
	wire [31:0] rd_cnt   = {24'h00_0000, tick_counter};
	wire [31:0] rd_rst   = {24'h00_0000, watchdog_overflow_flag, chip_reset_enable, 1'b0,
		RST_RSVD};
	wire [31:0] rd_pwr   = {30'h0000_0000, standby_refused, standby};
	wire [31:0] rd_mux   = (paddr == ADDR_CTRL)   ? rd_ctrl :
		(paddr == ADDR_COUNT)  ? rd_cnt :
		(paddr == ADDR_RSTCTL) ? rd_rst :
		(paddr == ADDR_PWR)    ? rd_pwr : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Helper counts for the exact pulse lengths; a repetition that long is too costly
	logic [15:0] ovf_low_cycles;
	logic [15:0] rst_high_cycles;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_low_cycles <= 16'h0000;
		end else begin
			ovf_low_cycles <= overflow_out_n ? 16'h0000 : ovf_low_cycles + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_high_cycles <= 16'h0000;
		end else begin
			rst_high_cycles <= chip_reset ? rst_high_cycles + 16'h0001 : 16'h0000;
		end
	end

	// Assertions
	property p_ovf_pulse;
		@(posedge pclk) disable iff (!presetn)
		ovf_wd |=> !overflow_out_n [*8];
	endproperty
	a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too short");

	property p_ovf_end;
		@(posedge pclk) disable iff (!presetn)
		$rose(!overflow_out_n) |-> ##[1:300] overflow_out_n;
	endproperty
	a_ovf_end: assert property (p_ovf_end) else $error("overflow pulse did not end");

	property p_chip_rst;
		@(posedge pclk) disable iff (!presetn)
		wd_rst |=> chip_reset && !overflow_out_n;
	endproperty
	a_chip_rst: assert property (p_chip_rst) else $error("chip reset not with overflow");

	property p_no_rst;
		@(posedge pclk) disable iff (!presetn)
		$rose(chip_reset) |-> $past(chip_reset_enable);
	endproperty
	a_no_rst: assert property (p_no_rst) else $error("chip reset while disabled");

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		ovf_it |=> interval_irq && timer_ctrl_status.flag;
	endproperty
	a_irq: assert property (p_irq) else $error("interval overflow missed");

	property p_wflag;
		@(posedge pclk) disable iff (!presetn)
		ovf_wd |=> watchdog_overflow_flag;
	endproperty
	a_wflag: assert property (p_wflag) else $error("watchdog flag not set");

	property p_stop_zero;
		@(posedge pclk) disable iff (!presetn)
		!counting && !wr_count |=> tick_counter == COUNT_ZERO;
	endproperty
	a_stop_zero: assert property (p_stop_zero) else $error("stopped counter not zero");

	property p_write_wins;
		@(posedge pclk) disable iff (!presetn)
		wr_count |=> tick_counter == $past(wdata);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("counter write lost");

	property p_refuse;
		@(posedge pclk) disable iff (!presetn)
		wr_pwr && timer_ctrl_status.run && pwr_state == PWR_RUN |=> pwr_state == PWR_RUN;
	endproperty
	a_refuse: assert property (p_refuse) else $error("standby entered while running");

	property p_enter;
		@(posedge pclk) disable iff (!presetn)
		wr_pwr && !timer_ctrl_status.run && pwr_state == PWR_RUN |=> standby;
	endproperty
	a_enter: assert property (p_enter) else $error("standby not entered");

	property p_wake;
		@(posedge pclk) disable iff (!presetn)
		pwr_state == PWR_WAKE && tick && tick_counter == COUNT_MAX && !wr_count
			|=> !standby && tick_counter == COUNT_ZERO;
	endproperty
	a_wake: assert property (p_wake) else $error("standby did not end on rollover");

	property p_ovf_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(overflow_out_n) |-> ovf_low_cycles == 16'(OVF_LEN);
	endproperty
	a_ovf_len: assert property (p_ovf_len) else $error("overflow pulse length wrong");

	property p_rst_len;
		@(posedge pclk) disable iff (!presetn)
		$fell(chip_reset) |-> rst_high_cycles == 16'(RST_LEN);
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("chip reset length wrong");

	sequence s_wd_event;
		ovf_wd;
	endsequence

	sequence s_pulses_start;
		!overflow_out_n && watchdog_overflow_flag;
	endsequence

	property p_wd_start;
		@(posedge pclk) disable iff (!presetn)
		s_wd_event |=> s_pulses_start;
	endproperty
	a_wd_start: assert property (p_wd_start) else $error("flag and pulse apart");

	property p_timer_clr;
		@(posedge pclk) disable iff (!presetn)
		ovf_wd |=> tick_counter == COUNT_ZERO && !timer_ctrl_status.run;
	endproperty
	a_timer_clr: assert property (p_timer_clr) else $error("timer not cleared");

	property p_wflag_clr;
		@(posedge pclk) disable iff (!presetn)
		clr_wflag && !ovf_wd |=> !watchdog_overflow_flag;
	endproperty
	a_wflag_clr: assert property (p_wflag_clr) else $error("watchdog flag not cleared");

	property p_wflag_only;
		@(posedge pclk) disable iff (!presetn)
		!clr_wflag |=> !$fell(watchdog_overflow_flag);
	endproperty
	a_wflag_only: assert property (p_wflag_only) else $error("watchdog flag lost");

	property p_cre_keep;
		@(posedge pclk) disable iff (!presetn)
		!set_cre |=> $stable(chip_reset_enable);
	endproperty
	a_cre_keep: assert property (p_cre_keep) else $error("reset enable changed");

	property p_irq_drop;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && !wdata[BIT_FLAG] && !ovf_it |=> !interval_irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("interval request stuck");
endmodule : watchdog_unit

// ### tb/reset_monitor.sv
// External reset circuit model measuring overflow and chip reset pulses
`timescale 1ns/10ps
module reset_monitor (
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   overflow_out_n,
	input  wire logic   chip_reset,
	output logic [15:0] ovf_width,
	output logic [15:0] rst_width
);
	logic [15:0] ovf_cnt;
	logic [15:0] rst_cnt;

	// Only measures; the overflow line never loops back into presetn
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_cnt   <= 16'h0000;
			rst_cnt   <= 16'h0000;
			ovf_width <= 16'h0000;
			rst_width <= 16'h0000;
		end else begin
			ovf_cnt <= overflow_out_n ? 16'h0000 : ovf_cnt + 16'h0001;
			rst_cnt <= chip_reset ? rst_cnt + 16'h0001 : 16'h0000;
			if (overflow_out_n && ovf_cnt != 16'h0000) ovf_width <= ovf_cnt;
			if (!chip_reset && rst_cnt != 16'h0000) rst_width <= rst_cnt;
		end
	end
endmodule : reset_monitor

// ### tb/tb_watchdog_unit.sv
// Self-checking testbench of the watchdog interval timer
`timescale 1ns/10ps
module tb_watchdog_unit;
	import wdt_pkg::*;
	// Short pulse lengths keep the run brief
	localparam int OVF_N = 8;
	localparam int RST_N = 16;
	logic        pclk, presetn, psel, penable, pwrite, nmi_req;
	logic        pready, pslverr, overflow_out_n, chip_reset, interval_irq;
	logic        standby, standby_refused, hold_por_regs;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] ovf_width, rst_width;
	logic [8:0]  exp_q[$];
	logic [7:0]  key;
	int          fail_count, checks, seed, cyc, n;

	watchdog_unit #(.OVF_LEN(OVF_N), .RST_LEN(RST_N)) watchdog_unit_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nmi_req(nmi_req),
		.overflow_out_n(overflow_out_n), .chip_reset(chip_reset),
		.interval_irq(interval_irq), .standby(standby),
		.standby_refused(standby_refused), .hold_por_regs(hold_por_regs));

	reset_monitor reset_monitor_i (.pclk(pclk), .presetn(presetn),
		.overflow_out_n(overflow_out_n), .chip_reset(chip_reset),
		.ovf_width(ovf_width), .rst_width(rst_width));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp

	task end_sim;
		$display("Mismatches %0d in %0d checks", fail_count, checks);
		if (fail_count == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// A leading edge keeps release and the next setup out of one time step
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [8:0] e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		if (!w) exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wait_for(input int s, input int lim, output int t);
		for (t = 0; t < lim; t++) begin
			@(posedge pclk);
			if ((s == 0 && interval_irq === 1'b1) || (s == 1 && overflow_out_n === 1'b0) ||
			    (s == 2 && interval_irq === 1'b0) || (s == 3 && standby === 1'b1) ||
			    (s == 4 && standby === 1'b0) || (s == 5 && chip_reset === 1'b1) ||
			    (s == 6 && standby_refused === 1'b1)) break;
		end
		cmp("wait", 16'h0001, {15'h0000, t < lim});
	endtask : wait_for

	always @(posedge pclk) begin
		if (psel && penable) cmp("pready", 16'h0001, {15'h0000, pready});
		if (psel && penable && !pwrite && pready === 1'b1) begin
			cmp("read", exp_q.pop_front(), {pslverr, pslverr ? 8'h00 : prdata[7:0]});
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		seed = 32'hdb2e;
		{psel, penable, pwrite, nmi_req, presetn} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		{fail_count, checks, cyc} = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 16'h0000, 9'h018);
		apb(1'b0, ADDR_RSTCTL, 16'h0000, 9'h01F);
		apb(1'b0, 12'h010, 16'h0000, 9'h100);
		key = 8'($random(seed));
		if (key == KEY_COUNT || key == KEY_CTRL) key = 8'h00;
		apb(1'b1, ADDR_CTRL, {key, 8'h60}, 9'h000);
		apb(1'b0, ADDR_CTRL, 16'h0000, 9'h018);
		apb(1'b1, ADDR_COUNT, 16'h5A33, 9'h000);
		apb(1'b0, ADDR_COUNT, 16'h0000, 9'h000);
		apb(1'b1, ADDR_CTRL, 16'hA520, 9'h000);
		wait_for(0, 700, n);
		cmp("interval period", 16'h0001, {15'h0000, n >= 508 && n <= 516});
		apb(1'b0, ADDR_CTRL, 16'h0000, 9'h0B8);
		apb(1'b1, ADDR_PWR, 16'h0001, 9'h000);
		wait_for(6, 4, n);
		cmp("standby", 16'h0000, {15'h0000, standby});
		apb(1'b1, ADDR_CTRL, 16'hA520, 9'h000);
		wait_for(2, 8, n);
		apb(1'b1, ADDR_CTRL, 16'hA500, 9'h000);
		apb(1'b1, ADDR_CTRL, 16'hA560, 9'h000);
		wait_for(1, 700, n);
		repeat (OVF_N + 4) @(posedge pclk);
		cmp("ovf width", 16'(OVF_N), ovf_width);
		apb(1'b0, ADDR_CTRL, 16'h0000, 9'h018);
		apb(1'b0, ADDR_RSTCTL, 16'h0000, 9'h09F);
		apb(1'b1, ADDR_RSTCTL, 16'hA500, 9'h000);
		apb(1'b0, ADDR_RSTCTL, 16'h0000, 9'h01F);
		apb(1'b1, ADDR_RSTCTL, 16'h5A40, 9'h000);
		// Feed three times, one write lands on a tick, then leave it running so the overflow fires
		apb(1'b1, ADDR_CTRL, 16'hA560, 9'h000);
		repeat (3) apb(1'b1, ADDR_COUNT, 16'h5A00, 9'h000);
		wait_for(5, 700, n);
		cmp("fed delay", 16'h0001, {15'h0000, n >= 500});
		cmp("por hold", 16'h0001, {15'h0000, hold_por_regs});
		cmp("ovf with reset", 16'h0000, {15'h0000, overflow_out_n});
		repeat (RST_N + 4) @(posedge pclk);
		cmp("rst width", 16'(RST_N), rst_width);
		apb(1'b0, ADDR_RSTCTL, 16'h0000, 9'h0DF);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_RSTCTL, 16'h0000, 9'h01F);
		apb(1'b1, ADDR_PWR, 16'h0001, 9'h000);
		wait_for(3, 8, n);
		nmi_req <= 1'b1;
		wait_for(4, 700, n);
		cmp("wake delay", 16'h0001, {15'h0000, n >= 500});
		nmi_req <= 1'b0;
		end_sim();
	end
endmodule : tb_watchdog_unit
